// ---- dv/smc_eeprom_model.sv ----
// Behavioural serial EEPROM that answers on the master bus pair.
// Assumes resolved open-drain levels on scl and sda, pulled up when released.
`timescale 1ns/1ns
module smc_eeprom_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic mute,
  output logic sda_oe
);
  // ==========================================================================
  // Byte engine
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [15:0] ptr;
  logic rd;
  logic act;
  int bitn;
  int byten;
  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      bitn = 0;
      byten = 0;
      rd = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) act = 1'b0;
  end
  always @(posedge scl) begin
    if (act && bitn < 8) sh = {sh[6:0], sda};
    bitn++;
  end
  // Only the low address byte indexes the array; a small model is enough here.
  always @(negedge scl) begin
    if (act) begin
      sda_oe = 1'b0;
      if (bitn == 9) bitn = 0;
      if (bitn == 8 && !rd) begin
        case (byten)
          0: rd = sh[0];
          1: ptr[15:8] = sh;
          2: ptr[7:0] = sh;
          default: mem[ptr[7:0]] = sh;
        endcase
        sda_oe = ((byten > 0) || (sh[7:1] == DEV)) && !mute;
        byten++;
      end else if (bitn == 8) begin
        byten = 2;
      end else if (rd && byten == 1) begin
        sda_oe = ~mem[ptr[7:0]][7 - bitn];
      end
    end
  end
endmodule : smc_eeprom_model

// ---- dv/testbench.sv ----
// Self-checking bench for the SMBus control block and its EEPROM engine.
// Assumes the register port contract of the block and one EEPROM on the bus.
`timescale 1ns/1ns
module testbench;
  // ==========================================================================
  // Harness
  localparam logic [11:0] CT = smc_pkg::CTRL_OFS;
  localparam logic [11:0] EE = smc_pkg::EEP_OFS;
  localparam logic [11:0] IS = smc_pkg::IRQ_STS_OFS;
  localparam logic [31:0] CFG = 32'h0028_0010;
  logic clk, rst_n, boot_fast, csum_ok, other_low, mute, s_scl;
  logic irq, csum_pass, mscl_o, mscl_oe, msda_o, msda_oe, e_oe, sclf, sdaf, scl, sda;
  logic [31:0] rdata, v;
  smc_pkg::smc_req_s req;
  int err_total, total_checks, cyc, nf, n0;
  time tf, per, lo;
  assign scl = ~mscl_oe;
  assign sda = ~(msda_oe | e_oe | other_low);
  smc_top DUT (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .irq(irq),
    .boot_fast_mode(boot_fast), .init_checksum_ok(csum_ok), .init_checksum_pass(csum_pass),
    .master_bus_clock_pin_i(scl), .master_bus_clock_pin_o(mscl_o),
    .master_bus_clock_pin_oe(mscl_oe), .master_bus_data_pin_i(sda),
    .master_bus_data_pin_o(msda_o), .master_bus_data_pin_oe(msda_oe),
    .slave_bus_clock_pin_i(s_scl), .slave_bus_data_pin_i(s_scl),
    .slave_clock_filt(sclf), .slave_data_filt(sdaf));
  smc_eeprom_model EEM (.scl(scl), .sda(sda), .mute(mute), .sda_oe(e_oe));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end
  // Bus clock shape is taken on the fifth fall, clear of start and stop.
  always @(negedge scl) begin
    nf++;
    if (nf == 5) per = $time - tf;
    tf = $time;
  end
  always @(posedge scl) begin
    if (nf == 5) lo = $time - tf;
  end
  // ==========================================================================
  // Shared tasks
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : bus_rd
  task automatic wait_done(output logic [31:0] d);
    for (int i = 0; i < 3000; i++) begin
      bus_rd(EE, d);
      if (d[25]) break;
    end
    chk(32'(d[25:24]), 32'h2, "done without busy");
  endtask : wait_done
  task automatic do_reset(input logic fast);
    @(posedge clk);
    rst_n <= 1'b0;
    boot_fast <= fast;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    bus_rd(CT, v);
    chk(v, 32'h0000_0139, "ctrl reset");
    bus_rd(12'h440, v);
    chk(v, 32'h0, "unmapped read");
    bus_wr(12'h440, 32'hFFFF_FFFF);
    bus_wr(CT, 32'hFFFF_FFFF);
    bus_rd(CT, v);
    chk(v, 32'h003F_FFFF, "ctrl fields");
    bus_wr(CT, CFG);
    bus_wr(smc_pkg::IRQ_MSK_OFS, 32'h1);
  endtask : t_regs
  task automatic t_csum;
    repeat (3) @(negedge clk);
    chk(32'(csum_pass), 32'h0, "checksum fails");
    bus_wr(CT, CFG | 32'h0002_0000);
    repeat (3) @(negedge clk);
    chk(32'(csum_pass), 32'h1, "checksum forced");
    bus_wr(CT, CFG);
  endtask : t_csum
  task automatic t_filt;
    int d [3];
    for (int c = 0; c < 3; c++) begin
      bus_wr(CT, (CFG & 32'hFFF3_FFFF) | (32'(c) << 18));
      s_scl <= 1'b0;
      d[c] = 0;
      while (sclf !== 1'b0 && d[c] < 100) begin
        @(negedge clk);
        d[c]++;
      end
      chk(32'(sdaf), 32'h0, "slave data filtered");
      s_scl <= 1'b1;
      repeat (80) @(posedge clk);
    end
    chk(32'(d[0] - d[2]), 32'd50, "1 us filter");
    chk(32'(d[1] - d[2]), 32'd5, "100 ns filter");
    bus_wr(CT, CFG);
  endtask : t_filt
  task automatic t_write;
    nf = 0;
    bus_wr(EE, 32'h00A5_0012);
    bus_rd(EE, v);
    chk(32'(v[24]), 32'h1, "busy");
    wait_done(v);
    chk(v, 32'h02A5_0012, "write done");
    chk(32'(EEM.mem[8'h12]), 32'hA5, "byte stored");
    chk(32'({mscl_o, msda_o}), 32'h0, "pins pull low only");
    chk(32'(per inside {[560:620]}), 32'h1, "bus period");
    chk(32'(lo inside {[240:260]}), 32'h1, "bus low time");
    chk(32'(irq), 32'h1, "irq raised");
    bus_wr(IS, 32'h1);
    @(negedge clk);
    chk(32'(irq), 32'h0, "irq cleared");
  endtask : t_write
  task automatic t_read;
    bus_wr(EE, 32'h04FF_0012);
    bus_rd(EE, v);
    chk(32'(v[25:24]), 32'h1, "done low in progress");
    wait_done(v);
    chk(v, 32'h06A5_0012, "read data");
    bus_wr(IS, 32'h7);
  endtask : t_read
  task automatic t_fault(input logic arb, input logic iom, input logic [31:0] sts);
    bus_wr(CT, CFG | (32'(iom) << 16));
    mute <= ~arb;
    other_low <= arb;
    bus_wr(EE, 32'h0011_0020);
    wait_done(v);
    bus_rd(IS, v);
    chk(v, sts, "fault status");
    mute <= 1'b0;
    other_low <= 1'b0;
    bus_wr(IS, 32'h7);
    bus_wr(CT, CFG);
  endtask : t_fault
  task automatic t_freeze;
    bus_wr(CT, (CFG & 32'hFFFF_0000) | 32'h1);
    bus_wr(EE, 32'h005A_0033);
    repeat (20) @(negedge clk);
    n0 = nf;
    repeat (300) @(negedge clk);
    chk(32'(nf - n0), 32'h0, "clock stopped");
    bus_rd(EE, v);
    chk(32'(v[24]), 32'h1, "held busy");
    bus_wr(CT, CFG ^ 32'h0030_0000);
    wait_done(v);
    chk(32'(EEM.mem[8'h33]), 32'h5A, "resumed write");
  endtask : t_freeze
  initial begin
    rst_n = 1'b0;
    boot_fast = 1'b0;
    csum_ok = 1'b0;
    other_low = 1'b0;
    mute = 1'b0;
    s_scl = 1'b1;
    req = '0;
    do_reset(1'b0);
    t_regs();
    t_csum();
    t_filt();
    t_write();
    t_read();
    t_fault(1'b0, 1'b0, 32'h5);
    t_fault(1'b1, 1'b0, 32'h3);
    t_fault(1'b1, 1'b1, 32'h1);
    t_freeze();
    do_reset(1'b1);
    bus_rd(CT, v);
    chk(v, 32'h0000_0053, "fast boot prescale");
    complete_run();
  end
endmodule : testbench

// ---- include/smc_pkg.sv ----
// Shared constants, types and register layout of the SMBus control and EEPROM access block.
// Assumes a single 50 MHz core clock and a plain address/strobe register port.
package smc_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int PRESCALE_UNIT_NS = 32;
  localparam int FILT_NORMAL_NS = 1000;
  localparam int FILT_FAST_NS = 100;
  localparam logic [5:0] TICK_STEP = 6'(CLK_PERIOD_NS);
  localparam logic [5:0] TICK_UNIT = 6'(PRESCALE_UNIT_NS);
  localparam logic [5:0] FILT_NORMAL_CYC =
    6'((FILT_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] FILT_FAST_CYC =
    6'((FILT_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ARB_LOSS_LAST = 4'hF;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] INIT_LOAD = 2'h2;
  localparam logic [1:0] INIT_DONE = 2'h3;
  // ==========================================================================
  // Register map
  localparam logic [11:0] CTRL_OFS = 12'h428;
  localparam logic [11:0] EEP_OFS = 12'h42C;
  localparam logic [11:0] IRQ_STS_OFS = 12'h434;
  localparam logic [11:0] IRQ_MSK_OFS = 12'h438;
  localparam logic [15:0] PRESCALE_SLOW = 16'h0139;
  localparam logic [15:0] PRESCALE_FAST = 16'h0053;
  localparam int CTRL_USED_W = 22;
  localparam int EEP_DATA_LSB = 16;
  localparam int EEP_BUSY_BIT = 24;
  localparam int EEP_DONE_BIT = 25;
  localparam int EEP_OP_BIT = 26;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ARB = 1;
  localparam int IRQ_NACK = 2;
  localparam logic OP_WRITE = 1'b0;
  localparam logic OP_READ = 1'b1;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    FLT_NORMAL = 2'b00, FLT_FAST = 2'b01, FLT_OFF = 2'b10, FLT_RSVD = 2'b11
  } smc_flt_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_START = 3'b001, ST_SEND = 3'b010, ST_RECV = 3'b011,
    ST_RSTART = 3'b100, ST_STOP = 3'b101, ST_WAIT = 3'b110
  } smc_st_e;
  typedef struct packed {
    logic [9:0] rsvd;
    smc_flt_e mmode;
    smc_flt_e smode;
    logic csum;
    logic iom;
    logic [15:0] prescale;
  } smc_ctrl_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } smc_req_s;
endpackage : smc_pkg

// ---- src/smc_top.sv ----
// SMBus control registers, bus glitch filters and a byte access engine for a serial EEPROM.
// Assumes one 50 MHz clock, a same-clock register master, and open-drain bus pins.
// ==========================================================================
// Summary of operation
// - Master bit clock period is 32 ns times the 16-bit prescale field.
// - A prescale of zero or one stops the master bus clock.
// - Prescale loads 0x0139 for slow boot strap, fast value otherwise.
// - Master clock low time is half the programmed period, rounded up.
// - Ignore-other-masters keeps a transfer going after a lost arbitration.
// - Ignore-checksum forces the init checksum to pass.
// - Slave line filters delay 1 us, 100 ns or nothing by code.
// - Master line filters use the same two-bit delay coding.
// - The 16-bit address field selects the EEPROM byte accessed.
// - Writing the data field launches one EEPROM operation.
// - Writes store the byte; reads return the fetched byte at completion.
// - Busy reads high while an EEPROM operation runs.
// - Done sets at completion, clears by writing one, zero while running.
// - Operation select is 0 for write, 1 for read.
// - Lost arbitration retries; sixteen losses abort and raise the error flag.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module smc_top #(
  parameter logic [6:0] EEPROM_DEV_ADDR = 7'h50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire smc_pkg::smc_req_s reg_req,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic boot_fast_mode,
  input wire logic init_checksum_ok,
  output logic init_checksum_pass,
  input wire logic master_bus_clock_pin_i,
  output logic master_bus_clock_pin_o,
  output logic master_bus_clock_pin_oe,
  input wire logic master_bus_data_pin_i,
  output logic master_bus_data_pin_o,
  output logic master_bus_data_pin_oe,
  input wire logic slave_bus_clock_pin_i,
  input wire logic slave_bus_data_pin_i,
  output logic slave_clock_filt,
  output logic slave_data_filt
);
  // ==========================================================================
  // Declarations
  smc_pkg::smc_ctrl_s ctrl_r;
  smc_pkg::smc_st_e st_r;
  logic [1:0] init_cnt_r;
  logic boot_s1_r, boot_s2_r;
  logic [15:0] addr_r;
  logic [7:0] data_r;
  logic op_r, done_r, nack_r, ack_r, csum_r;
  logic [smc_pkg::IRQ_W-1:0] sts_r, msk_r;
  logic [31:0] rdata_r;
  logic [5:0] acc_r;
  logic [5:0] acc_sum;
  logic tick_r;
  logic [15:0] tc_r;
  logic [3:0] bc_r;
  logic [2:0] bi_r;
  logic [3:0] loss_r;
  logic [7:0] rx_r;
  logic scl_oe_r, sda_oe_r;
  logic [3:0] raw_w, sy1_r, sy2_r, flt_r;
  logic [5:0] cnt_r [4];
  logic [5:0] lim_w [4];
  logic busy_w, run_w, active_w, stall_w, step_w;
  logic ev_q, ev_s, ev_e;
  logic [15:0] lo_w, qt_w, smp_w, end_w;
  logic [7:0] tx_byte_w;
  logic tx_bit_w, ack_now, arb_lost_w, arb_abort_w, done_set, read_ok_w;
  logic launch_w, wr_ctrl, wr_eep, wr_sts, wr_msk;
  logic [smc_pkg::IRQ_W-1:0] sts_set;
  logic scl_f, sda_f;

  assign wr_ctrl = reg_req.wr && reg_req.addr == smc_pkg::CTRL_OFS;
  assign wr_eep = reg_req.wr && reg_req.addr == smc_pkg::EEP_OFS;
  assign wr_sts = reg_req.wr && reg_req.addr == smc_pkg::IRQ_STS_OFS;
  assign wr_msk = reg_req.wr && reg_req.addr == smc_pkg::IRQ_MSK_OFS;
  assign busy_w = st_r != smc_pkg::ST_IDLE;
  assign launch_w = wr_eep && !busy_w;

  // ==========================================================================
  // Control register and boot strap load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_s1_r <= 1'b0;
      boot_s2_r <= 1'b0;
    end else begin
      boot_s1_r <= boot_fast_mode;
      boot_s2_r <= boot_s1_r;
    end
  end

  // The strap is taken two cycles after release so the synchroniser has settled.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_cnt_r <= 2'h0;
      ctrl_r <= '0;
      ctrl_r.prescale <= smc_pkg::PRESCALE_SLOW;
    end else begin
      if (init_cnt_r != smc_pkg::INIT_DONE) begin
        init_cnt_r <= init_cnt_r + 2'h1;
      end
      if (wr_ctrl) begin
        ctrl_r <= smc_pkg::smc_ctrl_s'({10'h000, reg_req.wdata[smc_pkg::CTRL_USED_W-1:0]});
      end else if (init_cnt_r == smc_pkg::INIT_LOAD) begin
        ctrl_r.prescale <= boot_s2_r ? smc_pkg::PRESCALE_FAST : smc_pkg::PRESCALE_SLOW;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      csum_r <= 1'b0;
    end else begin
      csum_r <= init_checksum_ok || ctrl_r.csum;
    end
  end
  assign init_checksum_pass = csum_r;

  // ==========================================================================
  // Glitch filters: 0..1 master clock/data, 2..3 slave clock/data
  assign raw_w = {slave_bus_data_pin_i, slave_bus_clock_pin_i,
                  master_bus_data_pin_i, master_bus_clock_pin_i};

  function automatic logic [5:0] flt_lim(input smc_pkg::smc_flt_e m);
    logic [5:0] v;
    v = smc_pkg::FILT_NORMAL_CYC;
    unique case (m)
      smc_pkg::FLT_FAST: v = smc_pkg::FILT_FAST_CYC;
      smc_pkg::FLT_OFF: v = 6'h00;
      // The reserved code behaves as the normal 1 us filter.
      default: v = smc_pkg::FILT_NORMAL_CYC;
    endcase
    return v;
  endfunction : flt_lim

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flt
      assign lim_w[gi] = flt_lim(gi < 2 ? ctrl_r.mmode : ctrl_r.smode);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sy1_r[gi] <= 1'b1;
          sy2_r[gi] <= 1'b1;
          flt_r[gi] <= 1'b1;
          cnt_r[gi] <= 6'h00;
        end else begin
          sy1_r[gi] <= raw_w[gi];
          sy2_r[gi] <= sy1_r[gi];
          if (sy2_r[gi] == flt_r[gi] || lim_w[gi] == 6'h00) begin
            flt_r[gi] <= sy2_r[gi];
            cnt_r[gi] <= 6'h00;
          end else if (cnt_r[gi] >= lim_w[gi]) begin
            flt_r[gi] <= sy2_r[gi];
            cnt_r[gi] <= 6'h00;
          end else begin
            cnt_r[gi] <= cnt_r[gi] + 6'h01;
          end
        end
      end
    end
  endgenerate
  assign scl_f = flt_r[0];
  assign sda_f = flt_r[1];
  assign slave_clock_filt = flt_r[2];
  assign slave_data_filt = flt_r[3];

  // ==========================================================================
  // Prescaler time base
  // A 32 ns unit does not divide the 20 ns clock, so the unit tick comes from a
  // fractional accumulator; single bits jitter by one clock but periods average exactly.
  assign acc_sum = acc_r + smc_pkg::TICK_STEP;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r <= 6'h00;
      tick_r <= 1'b0;
    end else if (acc_sum >= smc_pkg::TICK_UNIT) begin
      acc_r <= acc_sum - smc_pkg::TICK_UNIT;
      tick_r <= 1'b1;
    end else begin
      acc_r <= acc_sum;
      tick_r <= 1'b0;
    end
  end

  assign run_w = ctrl_r.prescale > 16'h0001;
  assign lo_w = ctrl_r.prescale - (ctrl_r.prescale >> 1);
  assign qt_w = lo_w >> 1;
  assign smp_w = lo_w + ((ctrl_r.prescale - lo_w) >> 1);
  assign end_w = ctrl_r.prescale - 16'h0001;
  assign active_w = busy_w && st_r != smc_pkg::ST_WAIT;
  // Clock stretching by a slave holds the slot while the line stays low.
  assign stall_w = active_w && tc_r >= lo_w && !scl_f;
  assign step_w = tick_r && run_w && !stall_w;
  assign ev_q = step_w && tc_r == qt_w;
  assign ev_s = step_w && tc_r == smp_w;
  assign ev_e = step_w && tc_r == end_w;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tc_r <= 16'h0000;
    end else if (!busy_w || launch_w) begin
      tc_r <= 16'h0000;
    end else if (step_w) begin
      tc_r <= ev_e ? 16'h0000 : tc_r + 16'h0001;
    end
  end

  // ==========================================================================
  // Byte sequencer
  always_comb begin
    tx_byte_w = {EEPROM_DEV_ADDR, smc_pkg::OP_WRITE};
    unique case (bi_r)
      3'h1: tx_byte_w = addr_r[15:8];
      3'h2: tx_byte_w = addr_r[7:0];
      3'h3: tx_byte_w = op_r ? {EEPROM_DEV_ADDR, smc_pkg::OP_READ} : data_r;
      default: tx_byte_w = {EEPROM_DEV_ADDR, smc_pkg::OP_WRITE};
    endcase
  end
  assign tx_bit_w = bc_r < smc_pkg::BIT_ACK ? tx_byte_w[3'(4'h7 - bc_r)] : 1'b1;
  assign ack_now = ev_s ? sda_f : ack_r;
  assign arb_lost_w = ev_s && st_r == smc_pkg::ST_SEND && bc_r < smc_pkg::BIT_ACK
                      && tx_bit_w && !sda_f && !ctrl_r.iom;
  assign arb_abort_w = arb_lost_w && loss_r == smc_pkg::ARB_LOSS_LAST;
  assign done_set = (ev_e && st_r == smc_pkg::ST_STOP) || arb_abort_w;
  assign read_ok_w = ev_e && st_r == smc_pkg::ST_STOP && op_r == smc_pkg::OP_READ && !nack_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rx_r <= 8'h00;
    end else if (ev_s && st_r == smc_pkg::ST_SEND && bc_r == smc_pkg::BIT_ACK) begin
      ack_r <= sda_f;
    end else if (ev_s && st_r == smc_pkg::ST_RECV && bc_r < smc_pkg::BIT_ACK) begin
      rx_r <= {rx_r[6:0], sda_f};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= smc_pkg::ST_IDLE;
      bc_r <= 4'h0;
      bi_r <= 3'h0;
      loss_r <= 4'h0;
      nack_r <= 1'b0;
    end else if (launch_w) begin
      st_r <= smc_pkg::ST_START;
      bc_r <= 4'h0;
      bi_r <= 3'h0;
      loss_r <= 4'h0;
      nack_r <= 1'b0;
    end else if (arb_lost_w) begin
      loss_r <= loss_r + 4'h1;
      bc_r <= 4'h0;
      bi_r <= 3'h0;
      st_r <= arb_abort_w ? smc_pkg::ST_IDLE : smc_pkg::ST_WAIT;
    end else if (ev_e) begin
      unique case (st_r)
        smc_pkg::ST_WAIT: st_r <= smc_pkg::ST_START;
        smc_pkg::ST_START, smc_pkg::ST_RSTART: begin
          st_r <= smc_pkg::ST_SEND;
          bc_r <= 4'h0;
        end
        smc_pkg::ST_SEND: begin
          if (bc_r != smc_pkg::BIT_ACK) begin
            bc_r <= bc_r + 4'h1;
          end else begin
            bc_r <= 4'h0;
            loss_r <= 4'h0;
            if (ack_now) begin
              nack_r <= 1'b1;
              st_r <= smc_pkg::ST_STOP;
            end else if (bi_r == 3'h2 && op_r == smc_pkg::OP_READ) begin
              st_r <= smc_pkg::ST_RSTART;
              bi_r <= 3'h3;
            end else if (bi_r == 3'h3) begin
              st_r <= op_r == smc_pkg::OP_READ ? smc_pkg::ST_RECV : smc_pkg::ST_STOP;
            end else begin
              bi_r <= bi_r + 3'h1;
            end
          end
        end
        smc_pkg::ST_RECV: begin
          if (bc_r != smc_pkg::BIT_ACK) begin
            bc_r <= bc_r + 4'h1;
          end else begin
            bc_r <= 4'h0;
            st_r <= smc_pkg::ST_STOP;
          end
        end
        smc_pkg::ST_STOP: st_r <= smc_pkg::ST_IDLE;
        default: st_r <= smc_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Open-drain pin drive: the pins only ever pull low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= active_w && !arb_lost_w && tc_r < lo_w;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_oe_r <= 1'b0;
    end else if (!busy_w || arb_lost_w) begin
      sda_oe_r <= 1'b0;
    end else if (ev_q) begin
      unique case (st_r)
        smc_pkg::ST_SEND: sda_oe_r <= !tx_bit_w;
        smc_pkg::ST_STOP: sda_oe_r <= 1'b1;
        default: sda_oe_r <= 1'b0;
      endcase
    end else if (ev_s) begin
      if (st_r == smc_pkg::ST_START || st_r == smc_pkg::ST_RSTART) begin
        sda_oe_r <= 1'b1;
      end else if (st_r == smc_pkg::ST_STOP) begin
        sda_oe_r <= 1'b0;
      end
    end
  end
  assign master_bus_clock_pin_o = 1'b0;
  assign master_bus_data_pin_o = 1'b0;
  assign master_bus_clock_pin_oe = scl_oe_r;
  assign master_bus_data_pin_oe = sda_oe_r;

  // ==========================================================================
  // EEPROM access register
  // A write while busy is dropped whole, except that its done bit still clears.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_r <= 16'h0000;
      data_r <= 8'h00;
      op_r <= smc_pkg::OP_WRITE;
    end else if (launch_w) begin
      addr_r <= reg_req.wdata[15:0];
      data_r <= reg_req.wdata[smc_pkg::EEP_DATA_LSB +: 8];
      op_r <= reg_req.wdata[smc_pkg::EEP_OP_BIT];
    end else if (read_ok_w) begin
      data_r <= rx_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else if (done_set) begin
      done_r <= 1'b1;
    end else if (launch_w || (wr_eep && reg_req.wdata[smc_pkg::EEP_DONE_BIT])) begin
      done_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  assign sts_set = {done_set && nack_r, arb_abort_w, done_set};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sts_r <= '0;
      msk_r <= '0;
    end else begin
      sts_r <= (sts_r & ~(wr_sts ? reg_req.wdata[smc_pkg::IRQ_W-1:0] : '0)) | sts_set;
      if (wr_msk) begin
        msk_r <= reg_req.wdata[smc_pkg::IRQ_W-1:0];
      end
    end
  end
  assign irq = |(sts_r & msk_r);

  // ==========================================================================
  // Register read port, data in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= 32'h0000_0000;
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          smc_pkg::CTRL_OFS: rdata_r <= ctrl_r;
          smc_pkg::EEP_OFS: rdata_r <= {5'h00, op_r, done_r, busy_w, data_r, addr_r};
          smc_pkg::IRQ_STS_OFS: rdata_r <= {29'h0000_0000, sts_r};
          smc_pkg::IRQ_MSK_OFS: rdata_r <= {29'h0000_0000, msk_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_launch;
    launch_w;
  endsequence
  sequence s_started;
    st_r == smc_pkg::ST_START && !done_r && busy_w;
  endsequence

  AST_STOPPED: assert property (ctrl_r.prescale <= 16'h0001 |-> !step_w)
    else $error("master bit clock advanced while stopped");
  AST_TICK_RATE: assert property (tick_r ##1 tick_r |=> !tick_r)
    else $error("prescale unit tick faster than 32 ns");
  AST_SCL_LOW: assert property ($fell(scl_oe_r) && busy_w |-> $past(tc_r) >= lo_w)
    else $error("master clock low phase shorter than half period");
  AST_INIT: assert property (init_cnt_r == smc_pkg::INIT_LOAD && !wr_ctrl && !boot_s2_r
    |=> ctrl_r.prescale == smc_pkg::PRESCALE_SLOW)
    else $error("slow prescale not loaded at init");
  AST_IOM: assert property (ctrl_r.iom |-> !arb_lost_w)
    else $error("arbitration loss acted on while overridden");
  AST_CSUM: assert property (ctrl_r.csum |=> init_checksum_pass)
    else $error("checksum not forced to pass");
  AST_FILT_OFF: assert property (ctrl_r.smode == smc_pkg::FLT_OFF && $stable(ctrl_r.smode)
    |=> slave_clock_filt == $past(sy2_r[2]))
    else $error("slave filter delays in disabled mode");
  AST_MFILT: assert property ($changed(scl_f) && ctrl_r.mmode == smc_pkg::FLT_FAST
    && $stable(ctrl_r.mmode) |-> $past(sy2_r[0], 5) == scl_f)
    else $error("master filter passed a short pulse");
  AST_LAUNCH: assert property (s_launch |=> s_started)
    else $error("data write did not launch an operation");
  AST_ABORT: assert property (arb_abort_w |-> loss_r == smc_pkg::ARB_LOSS_LAST
    ##1 (sts_r[smc_pkg::IRQ_ARB] && done_r && !busy_w))
    else $error("arbitration abort not after sixteen losses");
  AST_DONE: assert property (done_set |=> done_r && !busy_w)
    else $error("done not set at completion");
  AST_READ: assert property (read_ok_w |=> data_r == $past(rx_r))
    else $error("read byte not returned in data field");
endmodule : smc_top
